// [src/scpc_pkg.sv]
// constants and types shared by the clock mode and pll control block
// assumes a single 40 MHz clk_i and a classic wishbone register port
package scpc_pkg;
  // bus clock and time base rate
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TB_PERIOD_NS = 1000;
  // 1 MHz time base tick, in clk_i cycles
  localparam int unsigned TB_DIV = TB_PERIOD_NS / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_STAT = 5'h04;
  localparam logic [4:0] ADR_TB = 5'h08;
  localparam logic [4:0] ADR_DEC = 5'h0c;
  // control register fields
  localparam int unsigned CTRL_MF_LSB = 0;
  localparam int unsigned CTRL_RFD_LSB = 8;
  localparam int unsigned CTRL_LOSS_OF_LOCK_RESET_ENABLE_BIT = 16;
  localparam int unsigned CTRL_WUR_BIT = 17;
  localparam int unsigned CTRL_DBG_BIT = 18;
  // status register fields
  localparam int unsigned STAT_LOCK_BIT = 0;
  localparam int unsigned STAT_WAKE_BIT = 1;
  localparam int unsigned STAT_LOL_BIT = 2;
  localparam int unsigned STAT_MODE_LSB = 4;
  // reset values of the frequency fields
  localparam logic [3:0] MF_RESET = 4'h2;
  localparam logic [3:0] RFD_RESET = 4'h3;
  // multiplier offset and largest prescaler exponent
  localparam logic [3:0] MULT_BASE = 4'h4;
  localparam int unsigned RFD_MAX = 10;
  // digital vco half period limits, in clk_i cycles
  localparam logic [7:0] DCO_HALF_RESET = 8'h04;
  localparam logic [7:0] DCO_HALF_MIN = 8'h01;
  localparam logic [7:0] DCO_HALF_MAX = 8'hff;
  // lock detector: largest phase error and good comparisons needed
  localparam logic [7:0] LOCK_TOL = 8'h02;
  localparam logic [3:0] LOCK_COUNT = 4'h8;
  // clock source modes, one-hot
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_ONE = 4'h2,
    MODE_BYPASS = 4'h4,
    MODE_TEST = 4'h8
  } scpc_mode_e;
endpackage

// [src/scpc_pd_if.sv]
// signals between the loop logic and the phase detector
// assumes both ends run on clk_i
`timescale 1ns/100ps
interface scpc_pd_if;
  logic ref_fall; // reference falling edge, one cycle
  logic fb_fall; // feedback falling edge, one cycle
  logic up; // feedback lags
  logic down; // feedback leads
  logic adj_fast; // end of an up pulse
  logic adj_slow; // end of a down pulse
  modport det (input ref_fall, input fb_fall, output up, output down,
    output adj_fast, output adj_slow);
  modport loop (output ref_fall, output fb_fall, input up, input down,
    input adj_fast, input adj_slow);
endinterface

// [src/scpc_pow2_prescaler.sv]
// power of two output prescaler, outside the feedback loop
// assumes src_rise_i marks the rising edges of src_i on clk_i
`timescale 1ns/100ps
module scpc_pow2_prescaler #(
  parameter int unsigned MAX_EXP = scpc_pkg::RFD_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_i,
  input wire logic src_rise_i,
  input wire logic [3:0] code_i,
  output logic out_o
);
  import scpc_pkg::*;
  localparam logic [3:0] MAX_CODE = 4'(MAX_EXP);
  // exponent must fit the four bit code
  if (MAX_EXP < 1 || MAX_EXP > 15)
  begin : g_chk
    $error("prescaler exponent out of range");
  end
  logic [MAX_EXP-1:0] cnt; // ripple count of source edges
  logic [MAX_EXP-1:0] next_cnt;
  logic next_out;
  logic [3:0] eff; // clamped exponent
  // codes above the largest divide like the largest
  // nonzero code divides
  always_comb
  begin
    eff = (code_i > MAX_CODE) ? MAX_CODE : code_i;
    next_cnt = src_rise_i ? cnt + 1'b1 : cnt;
    if (eff == 4'h0)
      next_out = src_i;
    else
      next_out = next_cnt[eff-4'h1];
  end
  // registered output keeps the pin glitch free
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= '0;
      out_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      out_o <= next_out;
    end
  end
  property p_presc_edge;
    @(posedge clk_i) disable iff (rst_i)
      // out_o follows the code of one cycle back, so that code must hold over two
      ($past(eff) != 4'h0 && $past(eff) == $past(eff, 2) && out_o != $past(out_o))
        |-> $past(src_rise_i);
  endproperty
  a_presc_edge: assert property (p_presc_edge) else $error("prescaler moved off edge");
  property p_presc_half;
    @(posedge clk_i) disable iff (rst_i)
      (eff == 4'h1 && $past(eff) == 4'h1 && src_rise_i) |=> (out_o != $past(out_o));
  endproperty
  a_presc_half: assert property (p_presc_half) else $error("divide by two missed");
endmodule

// [src/scpc_phase_detector.sv]
// falling edge phase and frequency detector
// assumes edge pulses last one clk_i cycle
`timescale 1ns/100ps
module scpc_phase_detector (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  scpc_pd_if.det pd
);
  import scpc_pkg::*;
  logic up, dn, fast, slow;
  logic next_up, next_dn, next_fast, next_slow;
  // up opens on reference fall, down on feedback fall; both close together
  // up and down pulses
  always_comb
  begin
    next_up = up | pd.ref_fall;
    next_dn = dn | pd.fb_fall;
    next_fast = 1'b0;
    next_slow = 1'b0;
    if (next_up && next_dn)
    begin
      // the flag that opened first tells the direction
      next_fast = up;
      next_slow = dn;
      next_up = 1'b0;
      next_dn = 1'b0;
    end
    if (!enable_i)
    begin
      next_up = 1'b0;
      next_dn = 1'b0;
      next_fast = 1'b0;
      next_slow = 1'b0;
    end
  end
  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      up <= 1'b0;
      dn <= 1'b0;
      fast <= 1'b0;
      slow <= 1'b0;
    end
    else
    begin
      up <= next_up;
      dn <= next_dn;
      fast <= next_fast;
      slow <= next_slow;
    end
  end
  assign pd.up = up;
  assign pd.down = dn;
  assign pd.adj_fast = fast;
  assign pd.adj_slow = slow;
  property p_lag_up;
    @(posedge clk_i) disable iff (rst_i)
      (enable_i && !up && !dn && pd.ref_fall && !pd.fb_fall) |=> pd.up until pd.fb_fall;
  endproperty
  a_lag_up: assert property (p_lag_up) else $error("up pulse missing");
  property p_lead_dn;
    @(posedge clk_i) disable iff (rst_i)
      (enable_i && !up && !dn && pd.fb_fall && !pd.ref_fall) |=> pd.down;
  endproperty
  a_lead_dn: assert property (p_lead_dn) else $error("down pulse missing");
endmodule

// [src/scpc_top.sv]
// clock mode selection, digital pll model, prescaler, wakeup and time base
// assumes a classic wishbone master on clk_i; oscillator and mode pins async
//
// Summary of operation
// - mode pins sampled during reset pick clock
// - both high: normal, fully programmable pll
// - select low: clock equals oscillator, no prescale
// - supply low: pll off, half oscillator
// - both low: factory test, pll bypassed
// - nonzero prescaler slows clock in normal and test only
// - pll multiplies reference by four to eleven
// - prescaler writes never disturb pll lock
// - feedback: clock out in 1:1, divider otherwise
// - up when feedback lags, down when leads
// - 1:1 mode bypasses multiplier divider
// - 1:1 true lock, prescaler disabled
// - reference output copies oscillator exactly
// - lock pin shows lock or debug output
// - wakeup pin follows software request bit
// - decrementer reaching zero also asserts wakeup
// - time base and decrementer run at 1 MHz
// - lock reset enable off pll requests reset
// - reset loads multiplier two, prescaler three
// - prescaler divides by power of two, capped
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
module scpc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic oscillator_input_i,
  output logic oscillator_drive_o,
  input wire logic clock_mode_select_i,
  input wire logic synthesizer_supply_i,
  input wire logic debug_serial_out_i,
  output logic system_clock_output_o,
  output logic engineering_reference_output_o,
  output logic pll_lock_output_o,
  output logic power_down_wakeup_o,
  output logic loss_of_lock_reset_o,
  output logic pump_up_o,
  output logic pump_down_o,
  output scpc_pkg::scpc_mode_e clock_mode_o
);
  import scpc_pkg::*;
  localparam int TB_GAP = TB_DIV;
  localparam logic [5:0] TB_LAST = 6'(TB_DIV - 1);

  scpc_pd_if pd_bus (); // detector link

  // two flop synchronisers for the asynchronous pins
  logic osc_meta, osc_sync, osc_prev;
  logic cms_meta, cms_sync, syn_meta, syn_sync, dbg_meta, dbg_sync;
  always_ff @(posedge clk_i)
  begin
    osc_meta <= oscillator_input_i;
    osc_sync <= osc_meta;
    osc_prev <= osc_sync; // edge history, reads the second stage only
    cms_meta <= clock_mode_select_i;
    cms_sync <= cms_meta;
    syn_meta <= synthesizer_supply_i;
    syn_sync <= syn_meta;
    dbg_meta <= debug_serial_out_i;
    dbg_sync <= dbg_meta;
  end
  logic osc_rise, osc_fall;
  assign osc_rise = osc_sync & ~osc_prev;
  assign osc_fall = osc_prev & ~osc_sync;

  // mode decode from supply level and select pin
  function automatic scpc_mode_e decode_mode(input logic syn, input logic sel);
    case ({syn, sel})
      2'b11: decode_mode = MODE_NORMAL;
      2'b10: decode_mode = MODE_ONE;
      2'b01: decode_mode = MODE_BYPASS;
      default: decode_mode = MODE_TEST;
    endcase
  endfunction

  // byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[8*i +: 8] = nw[8*i +: 8];
    end
    merge = res;
  endfunction

  scpc_mode_e mode, next_mode;
  // mode tracks the pins only while reset is high, then freezes
  // sample during reset
  always_comb
  begin
    next_mode = mode;
    if (rst_i)
      next_mode = decode_mode(syn_sync, cms_sync);
  end
  always_ff @(posedge clk_i)
  begin
    mode <= next_mode;
  end
  logic pll_on; // vco runs in normal and 1:1 only
  assign pll_on = (mode == MODE_NORMAL) || (mode == MODE_ONE);

  // software state
  logic [3:0] mf, output_prescaler; // multiplier and prescaler fields
  logic loss_of_lock_reset_enable, wakeup_request_bit, dbg_sel, dec_wake, ack;
  logic [31:0] dec, tb, rdat;
  logic [3:0] next_mf, next_rfd;
  logic next_loss_of_lock_reset_enable, next_wur, next_dbg_sel, next_dec_wake, next_ack;
  logic [31:0] next_dec, next_tb, next_rdat, ctrl_word, stat_word, nctrl;
  logic [5:0] tb_cnt, next_tb_cnt; // 1 MHz divider
  logic tick, hit, wr, mf_wr, locked, lol;

  // one decode for read and write
  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[CTRL_MF_LSB +: 4] = mf;
    ctrl_word[CTRL_RFD_LSB +: 4] = output_prescaler;
    ctrl_word[CTRL_LOSS_OF_LOCK_RESET_ENABLE_BIT] = loss_of_lock_reset_enable;
    ctrl_word[CTRL_WUR_BIT] = wakeup_request_bit;
    ctrl_word[CTRL_DBG_BIT] = dbg_sel;
    stat_word = '0;
    stat_word[STAT_LOCK_BIT] = locked;
    stat_word[STAT_WAKE_BIT] = dec_wake;
    stat_word[STAT_LOL_BIT] = lol;
    stat_word[STAT_MODE_LSB +: 4] = mode;
  end

  // bus, control fields, time base and decrementer
  always_comb
  begin
    hit = wb_cyc_i & wb_stb_i & ~ack;
    wr = hit & wb_we_i;
    nctrl = merge(ctrl_word, wb_dat_i, wb_sel_i);
    next_ack = hit;
    next_rdat = rdat;
    next_mf = mf;
    next_rfd = output_prescaler;
    next_loss_of_lock_reset_enable = loss_of_lock_reset_enable;
    next_wur = wakeup_request_bit;
    next_dbg_sel = dbg_sel;
    next_dec = dec;
    next_dec_wake = dec_wake;
    mf_wr = 1'b0;
    // unmapped offsets read zero and ignore writes
    if (hit && !wb_we_i)
    begin
      case (wb_adr_i)
        ADR_CTRL: next_rdat = ctrl_word;
        ADR_STAT: next_rdat = stat_word;
        ADR_TB: next_rdat = tb;
        ADR_DEC: next_rdat = dec;
        default: next_rdat = '0;
      endcase
    end
    if (wr && wb_adr_i == ADR_CTRL)
    begin
      next_mf = nctrl[CTRL_MF_LSB +: 4];
      next_rfd = nctrl[CTRL_RFD_LSB +: 4];
      next_loss_of_lock_reset_enable = nctrl[CTRL_LOSS_OF_LOCK_RESET_ENABLE_BIT];
      next_wur = nctrl[CTRL_WUR_BIT];
      next_dbg_sel = nctrl[CTRL_DBG_BIT];
      mf_wr = (next_mf != mf);
    end
    // write one clears the decrementer wake flag
    if (wr && wb_adr_i == ADR_STAT && wb_sel_i[0] && wb_dat_i[STAT_WAKE_BIT])
      next_dec_wake = 1'b0;
    tick = (tb_cnt == TB_LAST);
    next_tb_cnt = tick ? 6'h00 : tb_cnt + 6'h01;
    next_tb = tick ? tb + 32'h1 : tb;
    if (tick)
      next_dec = dec - 32'h1;
    if (wr && wb_adr_i == ADR_DEC)
      next_dec = merge(dec, wb_dat_i, wb_sel_i);
    // reaching zero wins over a same cycle clear
    // decrementer wakeup
    if (tick && dec == 32'h1)
      next_dec_wake = 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mf <= MF_RESET;
      output_prescaler <= RFD_RESET;
      loss_of_lock_reset_enable <= 1'b0;
      wakeup_request_bit <= 1'b0;
      dbg_sel <= 1'b0;
      dec <= '0;
      dec_wake <= 1'b0;
      tb <= '0;
      tb_cnt <= '0;
      ack <= 1'b0;
      rdat <= '0;
    end
    else
    begin
      mf <= next_mf;
      output_prescaler <= next_rfd;
      loss_of_lock_reset_enable <= next_loss_of_lock_reset_enable;
      wakeup_request_bit <= next_wur;
      dbg_sel <= next_dbg_sel;
      dec <= next_dec;
      dec_wake <= next_dec_wake;
      tb <= next_tb;
      tb_cnt <= next_tb_cnt;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;

  // digital vco, feedback divider and lock detector
  logic vco, next_vco, vco_rise, vco_tgl;
  logic [7:0] half, next_half, dco_cnt, next_dco_cnt, err, next_err;
  logic [3:0] fb_cnt, next_fb_cnt, mult, good, next_good;
  assign mult = MULT_BASE + {1'b0, mf[2:0]};
  assign vco_tgl = pll_on && (dco_cnt >= half - 8'h01);
  assign vco_rise = vco_tgl & ~vco;
  always_comb
  begin
    next_vco = pll_on ? (vco ^ vco_tgl) : 1'b0;
    next_dco_cnt = (!pll_on || vco_tgl) ? 8'h00 : dco_cnt + 8'h01;
    next_half = half;
    if (pd_bus.adj_fast && half > DCO_HALF_MIN)
      next_half = half - 8'h01;
    if (pd_bus.adj_slow && half < DCO_HALF_MAX)
      next_half = half + 8'h01;
    next_fb_cnt = fb_cnt;
    if (vco_rise)
      next_fb_cnt = (fb_cnt >= mult - 4'h1) ? 4'h0 : fb_cnt + 4'h1;
    // error width is the length of an up or down pulse
    next_err = (pd_bus.up || pd_bus.down) ? ((err == 8'hff) ? err : err + 8'h01) : err;
    next_good = good;
    if (pd_bus.adj_fast || pd_bus.adj_slow)
    begin
      next_err = 8'h00;
      if (err > LOCK_TOL)
        next_good = 4'h0;
      else if (good != LOCK_COUNT)
        next_good = good + 4'h1;
    end
    // a multiplier change or pll off drops lock, prescaler is outside the loop
    // prescaler leaves lock
    if (mf_wr || !pll_on)
      next_good = 4'h0;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vco <= 1'b0;
      dco_cnt <= '0;
      half <= DCO_HALF_RESET;
      fb_cnt <= '0;
      err <= '0;
      good <= '0;
    end
    else
    begin
      vco <= next_vco;
      dco_cnt <= next_dco_cnt;
      half <= next_half;
      fb_cnt <= next_fb_cnt;
      err <= next_err;
      good <= next_good;
    end
  end
  assign locked = (good == LOCK_COUNT);
  assign lol = loss_of_lock_reset_enable & ~locked;

  // feedback source: clock out itself in 1:1, divided vco in normal
  // feedback selection
  assign pd_bus.ref_fall = osc_fall;
  assign pd_bus.fb_fall = (mode == MODE_ONE) ? (vco_tgl & vco) :
    (vco_rise && fb_cnt == (mult >> 1) - 4'h1);

  scpc_phase_detector u_pd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(pll_on),
    .pd(pd_bus.det)
  );

  // prescaler source: vco, or raw oscillator in test mode
  logic psrc, psrc_rise, pout, half_clk, next_half_clk;
  assign psrc = (mode == MODE_TEST) ? osc_sync : vco;
  assign psrc_rise = (mode == MODE_TEST) ? osc_rise : vco_rise;
  scpc_pow2_prescaler #(
    .MAX_EXP(RFD_MAX)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(psrc),
    .src_rise_i(psrc_rise),
    .code_i(output_prescaler),
    .out_o(pout)
  );

  // output pins, all from flops
  logic next_sys;
  always_comb
  begin
    next_half_clk = osc_rise ? ~half_clk : half_clk;
    case (mode)
      MODE_NORMAL: next_sys = pout;
      MODE_ONE: next_sys = vco;
      MODE_BYPASS: next_sys = half_clk;
      MODE_TEST: next_sys = pout;
      default: next_sys = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      half_clk <= 1'b0;
      system_clock_output_o <= 1'b0;
      engineering_reference_output_o <= 1'b0;
      oscillator_drive_o <= 1'b1;
      pll_lock_output_o <= 1'b0;
      power_down_wakeup_o <= 1'b0;
      loss_of_lock_reset_o <= 1'b0;
    end
    else
    begin
      half_clk <= next_half_clk;
      system_clock_output_o <= next_sys;
      engineering_reference_output_o <= osc_sync;
      oscillator_drive_o <= ~osc_sync;
      pll_lock_output_o <= dbg_sel ? dbg_sync : locked;
      power_down_wakeup_o <= wakeup_request_bit | dec_wake;
      loss_of_lock_reset_o <= lol;
    end
  end
  assign pump_up_o = pd_bus.up;
  assign pump_down_o = pd_bus.down;
  assign clock_mode_o = mode;

  property p_mode_hold;
    @(posedge clk_i) (!rst_i && !$past(rst_i)) |-> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved after reset");
  property p_mode_pick;
    @(posedge clk_i) rst_i |=> (mode == decode_mode($past(syn_sync), $past(cms_sync)));
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not sampled");
  property p_bypass_half;
    @(posedge clk_i) disable iff (rst_i)
      (mode == MODE_BYPASS && osc_rise) |=> ##1 (system_clock_output_o != $past(system_clock_output_o));
  endproperty
  a_bypass_half: assert property (p_bypass_half) else $error("bypass not half rate");
  property p_test_unlocked;
    @(posedge clk_i) disable iff (rst_i) (mode == MODE_TEST) |-> !locked && !vco;
  endproperty
  a_test_unlocked: assert property (p_test_unlocked) else $error("pll ran in test");
  property p_fb_div;
    @(posedge clk_i) disable iff (rst_i) (mode == MODE_NORMAL && pd_bus.fb_fall) |-> vco_rise;
  endproperty
  a_fb_div: assert property (p_fb_div) else $error("feedback not from divider");
  property p_one_vco;
    @(posedge clk_i) disable iff (rst_i) (mode == MODE_ONE) |=> system_clock_output_o == $past(vco);
  endproperty
  a_one_vco: assert property (p_one_vco) else $error("1:1 output prescaled");
  property p_ecr;
    @(posedge clk_i) disable iff (rst_i)
      osc_rise |=> engineering_reference_output_o ##1 (engineering_reference_output_o == $past(osc_sync));
  endproperty
  a_ecr: assert property (p_ecr) else $error("reference output not a copy");
  property p_lock_pin;
    @(posedge clk_i) disable iff (rst_i) !dbg_sel |=> pll_lock_output_o == $past(locked);
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");
  sequence s_dec_zero;
    tick && dec == 32'h1;
  endsequence
  sequence s_wake_out;
    dec_wake ##1 power_down_wakeup_o;
  endsequence
  property p_dec_wake;
    @(posedge clk_i) disable iff (rst_i) s_dec_zero |=> s_wake_out;
  endproperty
  a_dec_wake: assert property (p_dec_wake) else $error("decrementer wakeup lost");
  property p_wur;
    @(posedge clk_i) disable iff (rst_i) $rose(wakeup_request_bit) |=> power_down_wakeup_o;
  endproperty
  a_wur: assert property (p_wur) else $error("wakeup bit not on pin");
  property p_tick_gap;
    @(posedge clk_i) disable iff (rst_i) tick |-> ##TB_GAP tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("time base not 1 MHz");
  property p_lol_off;
    @(posedge clk_i) disable iff (rst_i) (loss_of_lock_reset_enable && !pll_on) |=> loss_of_lock_reset_o;
  endproperty
  a_lol_off: assert property (p_lol_off) else $error("no lock reset request");
  property p_reset_fields;
    @(posedge clk_i) $fell(rst_i) |-> (mf == MF_RESET && output_prescaler == RFD_RESET);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("reset fields wrong");
  property p_rfd_lock;
    @(posedge clk_i) disable iff (rst_i)
      (locked && !mf_wr && !pd_bus.adj_fast && !pd_bus.adj_slow) |=> locked;
  endproperty
  a_rfd_lock: assert property (p_rfd_lock) else $error("lock lost without cause");
endmodule

// [test/scpc_osc_model.sv]
// crystal oscillator stand-in driving the oscillator pin
// assumes clk_i is the 40 MHz bench clock; half_i >= 2
`timescale 1ns/100ps
module scpc_osc_model (
  input wire logic clk_i,
  input wire logic [7:0] half_i,
  output logic osc_o
);
  logic [7:0] cnt = 8'h00; // cycles spent in this half
  initial osc_o = 1'b0;
  // free running, 50% duty, which bypass mode needs
  always @(posedge clk_i)
  begin
    cnt <= (cnt >= half_i - 8'h01) ? 8'h00 : cnt + 8'h01;
    if (cnt >= half_i - 8'h01)
      osc_o <= !osc_o;
  end
endmodule

// [test/system_clock_mode_and_pll_control_bench.sv]
// self-checking bench for the clock mode and pll control block
// assumes scpc_top with fixed one-cycle wishbone answer
`timescale 1ns/100ps
module system_clock_mode_and_pll_control_bench;
  import scpc_pkg::*;
  typedef struct {logic w; logic [4:0] a; logic [31:0] d, m, e;} scpc_row_s;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'hf; // full words only
  logic [31:0] wdat = 32'h0, rdat, r, t0;
  logic ack, osc, odrv, modsel = 1'b1, vdd = 1'b1, dbg = 1'b0;
  logic sysclk, ecr, lock, wake, lol, up, dn, sp = 1'b0, ep = 1'b0;
  logic [7:0] half = 8'h04; // oscillator period of 8 clocks
  scpc_mode_e mode;
  int fails = 0, num_checks = 0, sys_n = 0, ecr_n = 0, tick = 0, ds, de;
  // register walk: reads compare masked data, writes ignore mask
  scpc_row_s rows[6] = '{
    '{1'b0, ADR_CTRL, 32'h0, 32'hffffffff, 32'h00000302},
    '{1'b0, ADR_STAT, 32'h0, 32'h000000f4, 32'h00000010},
    '{1'b0, 5'h10, 32'h0, 32'hffffffff, 32'h0},
    '{1'b1, 5'h14, 32'hffffffff, 32'h0, 32'h0},
    '{1'b1, ADR_CTRL, 32'h00000105, 32'h0, 32'h0},
    '{1'b0, ADR_CTRL, 32'h0, 32'hffffffff, 32'h00000105}};
  scpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .oscillator_input_i(osc),
    .oscillator_drive_o(odrv), .clock_mode_select_i(modsel),
    .synthesizer_supply_i(vdd), .debug_serial_out_i(dbg),
    .system_clock_output_o(sysclk), .engineering_reference_output_o(ecr),
    .pll_lock_output_o(lock), .power_down_wakeup_o(wake),
    .loss_of_lock_reset_o(lol), .pump_up_o(up), .pump_down_o(dn),
    .clock_mode_o(mode));
  scpc_osc_model osc_m (.clk_i(clk_i), .half_i(half), .osc_o(osc));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  // rising edge counters and hang guard
  always @(posedge clk_i)
  begin
    sp <= sysclk;
    ep <= ecr;
    sys_n <= sys_n + ((sysclk && !sp) ? 1 : 0);
    ecr_n <= ecr_n + ((ecr && !ep) ? 1 : 0);
    tick <= tick + 1;
    if (tick == 20000)
    begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // no local limit: only the bench timeout ends a hung wait
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // pins settle through the synchronisers before reset samples them
  task automatic rst_mode(input logic v, input logic m);
    @(posedge clk_i);
    vdd <= v;
    modsel <= m;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic measure();
    int s0, e0;
    s0 = sys_n;
    e0 = ecr_n;
    repeat (400) @(posedge clk_i);
    ds = sys_n - s0;
    de = ecr_n - e0;
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    // power-up reset: three edges carry the mode pins through the synchronisers
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      wb(rows[i].w, rows[i].a, rows[i].d, r);
      if (!rows[i].w)
        chk(r & rows[i].m, rows[i].e);
    end
    $display("register walk done");
    wb(1'b1, ADR_CTRL, 32'h00020302, r);
    repeat (3) @(posedge clk_i);
    chk({31'h0, wake}, 32'h1);
    wb(1'b1, ADR_CTRL, 32'h00000302, r);
    repeat (3) @(posedge clk_i);
    chk({31'h0, wake}, 32'h0);
    // decrementer from two reaches zero within two ticks
    wb(1'b1, ADR_DEC, 32'h2, r);
    repeat (120) @(posedge clk_i);
    chk({31'h0, wake}, 32'h1);
    wb(1'b0, ADR_STAT, 32'h0, r);
    chk(r & 32'h2, 32'h2);
    // decrementer has wrapped past zero by now
    wb(1'b0, ADR_DEC, 32'h0, r);
    chk(r & 32'hfffffff0, 32'hfffffff0);
    wb(1'b1, ADR_STAT, 32'h2, r);
    repeat (3) @(posedge clk_i);
    chk({31'h0, wake}, 32'h0);
    dbg <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h00040302, r);
    repeat (5) @(posedge clk_i);
    chk({31'h0, lock}, 32'h1);
    dbg <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk({31'h0, lock}, 32'h0);
    wb(1'b0, ADR_TB, 32'h0, r);
    t0 = r;
    repeat (397) @(posedge clk_i);
    wb(1'b0, ADR_TB, 32'h0, r);
    chk_rng(int'(r - t0), 9, 11);
    $display("wakeup, debug and time base done");
    // i[1] is supply, i[0] is select: test, bypass, 1:1, normal
    for (int i = 0; i < 4; i++)
    begin
      rst_mode(i[1], i[0]);
      chk({28'h0, mode}, {28'h0, 4'h8 >> i});
      modsel <= !modsel;
      repeat (8) @(posedge clk_i);
      chk({28'h0, mode}, {28'h0, 4'h8 >> i});
      measure();
      chk_rng(de, 49, 51);
      chk({31'h0, odrv ^ ecr}, 32'h1);
      if (i == 0)
        chk_rng(ds, 5, 7);
      if (i == 1)
        chk_rng(ds, 24, 26);
      if (i == 2)
        chk_rng(ds, 45, 55);
      if (i < 2)
      begin
        // prescaler to zero and lock reset enable set with pll off
        wb(1'b1, ADR_CTRL, 32'h00010002, r);
        repeat (4) @(posedge clk_i);
        chk({31'h0, lol}, 32'h1);
        chk({30'h0, up, dn}, 32'h0);
        measure();
        chk_rng(ds, i ? 24 : 48, i ? 26 : 52);
        // software takes the enable back while the pll is off
        wb(1'b1, ADR_CTRL, 32'h00000002, r);
        repeat (4) @(posedge clk_i);
        chk({31'h0, lol}, 32'h0);
      end
      $display("clock mode %0d done", i);
    end
    final_report();
  end
endmodule
